// ---- hdl/psf_pkg.sv ----
// ****************************************************************
// Program status word constants and carriers
// ****************************************************************
package psf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] PSF_ADDR_STATUS_WORD = 8'hD0;  // program_status_word
  localparam logic [7:0] PSF_STATUS_RESET     = 8'h00;  // Value after reset
  localparam logic [7:0] PSF_RDATA_UNMAPPED   = 8'h00;  // Answer to any other address

  // ****************************************************************
  // Field positions inside the status word
  // ****************************************************************
  localparam int PSF_BIT_CARRY      = 7;
  localparam int PSF_BIT_HALF_CARRY = 6;
  localparam int PSF_BIT_USER_A     = 5;
  localparam int PSF_BIT_BANK_HI    = 4;
  localparam int PSF_BIT_BANK_LO    = 3;
  localparam int PSF_BIT_OVERFLOW   = 2;
  localparam int PSF_BIT_USER_B     = 1;
  localparam int PSF_BIT_PARITY     = 0;

  // Each working register bank is eight bytes of internal RAM
  localparam int PSF_BANK_SHIFT = 3;

  // ****************************************************************
  // Carrier from the ALU and instruction execution
  // ****************************************************************
  typedef struct packed {
    logic arith_en;      // Arithmetic result: load carry, half carry, overflow
    logic carry_out;     // Carry out of the eighth bit
    logic carry_bit6;    // Carry out of the seventh bit
    logic nibble_carry;  // Carry between the nibbles
    logic bit_en;        // Boolean instruction writes its result to carry
    logic bit_val;       // Boolean result
  } psf_alu_t;

endpackage

// ---- hdl/psf_top.sv ----
// How it works
// - Arithmetic carry out sets carry bit 7
// - Carry acts as Boolean bit accumulator
// - Nibble carry sets half carry bit 6
// - Overflow bit 2 is XOR of carries
// - Parity bit 0 tracks accumulator odd ones
// - User flags bits 5 and 1 free
// - Bank value selects RAM base times eight
// - Bank field is bits 4 and 3
`timescale 1ns/1ps

module psf_top
  import psf_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Core side
  input  wire psf_alu_t   i_alu,
  input  wire logic [7:0] i_acc,
  output logic      [7:0] o_status,
  output logic            o_carry,
  output logic      [4:0] o_bank_base
);

  // ****************************************************************
  // Status word state
  // ****************************************************************
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [4:0] bank_base_reg;
  logic [4:0] bank_base_next;
  logic       sw_write;
  logic       sw_read;

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  // Only the one address is mapped; anything else is ignored on write
  assign sw_write = i_wr && (i_addr == PSF_ADDR_STATUS_WORD);
  assign sw_read  = i_rd && (i_addr == PSF_ADDR_STATUS_WORD);

  // ****************************************************************
  // Next status
  // ****************************************************************
  // Software write first, core updates override it, so a
  // flag produced by an instruction in the same cycle as a write is kept
  always_comb begin
    status_next = status_reg;
    if (sw_write) begin
      status_next = i_wdata;
    end
    if (i_alu.arith_en) begin
      status_next[PSF_BIT_CARRY]      = i_alu.carry_out;
      status_next[PSF_BIT_HALF_CARRY] = i_alu.nibble_carry;
      status_next[PSF_BIT_OVERFLOW]   = i_alu.carry_bit6 ^ i_alu.carry_out;
    end else if (i_alu.bit_en) begin
      status_next[PSF_BIT_CARRY] = i_alu.bit_val;
    end
    // Parity is never writable; it is recomputed from the accumulator
    status_next[PSF_BIT_PARITY] = ^i_acc;
  end

  // Bank base address, kept in a flop so the RAM decode sees a clean value;
  // worked out from the next status so it never lags the bank field
  always_comb begin
    bank_base_next = 5'(status_next[PSF_BIT_BANK_HI:PSF_BIT_BANK_LO]) << PSF_BANK_SHIFT;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data stands until the next enabled edge after the strobe only; any other
  // address answers with a fixed value so software never sees stale data
  always_comb begin
    rdata_next = PSF_RDATA_UNMAPPED;
    if (sw_read) begin
      rdata_next = status_reg;  // Word as it stood before this edge
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Status word; the clock enable freezes it, reset does not wait for it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      status_reg <= PSF_STATUS_RESET;
    end else if (i_ce) begin
      status_reg <= status_next;
    end
  end

  // Bank base starts where the reset value of the bank field points
  localparam logic [4:0] BANK_BASE_RESET =
    5'(PSF_STATUS_RESET[PSF_BIT_BANK_HI:PSF_BIT_BANK_LO]) << PSF_BANK_SHIFT;

  // Bank base register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bank_base_reg <= BANK_BASE_RESET;
    end else if (i_ce) begin
      bank_base_reg <= bank_base_next;
    end
  end

  // Read data register; an idle cycle returns it to the idle value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_reg <= PSF_RDATA_UNMAPPED;
    end else if (i_ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a flop or one bit of a flop, so the core sees no glitch
  assign o_status    = status_reg;
  assign o_carry     = status_reg[PSF_BIT_CARRY];
  assign o_rdata     = rdata_reg;
  assign o_bank_base = bank_base_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_carry_from_alu: assert property (i_ce && i_alu.arith_en |=> o_carry == $past(i_alu.carry_out))
    else $error("carry does not follow ALU carry out");

  a_carry_bool_op: assert property (i_ce && i_alu.bit_en && !i_alu.arith_en
                                    |=> o_carry == $past(i_alu.bit_val))
    else $error("carry does not take Boolean result");

  a_half_carry_set: assert property (i_ce && i_alu.arith_en
                                     |=> o_status[PSF_BIT_HALF_CARRY] == $past(i_alu.nibble_carry))
    else $error("half carry wrong");

  a_overflow_xor: assert property (i_ce && i_alu.arith_en
                                   |=> o_status[PSF_BIT_OVERFLOW] ==
                                       ($past(i_alu.carry_bit6) != $past(i_alu.carry_out)))
    else $error("overflow is not the XOR of the two carries");

  a_parity_tracks: assert property (i_ce |=> o_status[PSF_BIT_PARITY] == ^$past(i_acc))
    else $error("parity does not match accumulator");

  a_user_flags_wr: assert property (i_ce && sw_write ##1 !i_ce [*2]
                                    |-> o_status[PSF_BIT_USER_A] == $past(i_wdata[PSF_BIT_USER_A], 2)
                                     && o_status[PSF_BIT_USER_B] == $past(i_wdata[PSF_BIT_USER_B], 2))
    else $error("user flags lost written value");

  a_bank_base_map: assert property (o_bank_base ==
                                    5'({o_status[PSF_BIT_BANK_HI], o_status[PSF_BIT_BANK_LO]}) * 5'h08)
    else $error("bank base does not match bank field");

  a_bank_field_wr: assert property (i_ce && sw_write |=> o_status[PSF_BIT_BANK_HI] == $past(i_wdata[PSF_BIT_BANK_HI])
                                     && o_status[PSF_BIT_BANK_LO] == $past(i_wdata[PSF_BIT_BANK_LO]))
    else $error("bank field not written");

  a_parity_no_write: assert property (i_ce && sw_write && (i_wdata[PSF_BIT_PARITY] != ^i_acc)
                                      |=> o_status[PSF_BIT_PARITY] != $past(i_wdata[PSF_BIT_PARITY]))
    else $error("parity took written value");

  a_read_answer: assert property (i_ce && sw_read |=> o_rdata == $past(o_status))
    else $error("read data wrong");

  // ****************************************************************
  // Corner checks
  // ****************************************************************
  // User flags have no hardware meaning, so a write must land as is
  a_user_flags_take: assert property (i_ce && sw_write
                                      |=> o_status[PSF_BIT_USER_A] == $past(i_wdata[PSF_BIT_USER_A])
                                       && o_status[PSF_BIT_USER_B] == $past(i_wdata[PSF_BIT_USER_B]))
    else $error("user flags not written");

  // An arithmetic result outranks a Boolean result in the same cycle
  a_arith_beats_bool: assert property (i_ce && i_alu.arith_en && i_alu.bit_en
                                       |=> o_carry == $past(i_alu.carry_out))
    else $error("Boolean result beat arithmetic carry");

  // A Boolean op owns only the carry; half carry and overflow must hold
  a_bool_keeps_flags: assert property (i_ce && i_alu.bit_en && !i_alu.arith_en && !sw_write
                                       |=> $stable(o_status[PSF_BIT_HALF_CARRY])
                                        && $stable(o_status[PSF_BIT_OVERFLOW]))
    else $error("Boolean op touched half carry or overflow");

  // With no write and no core update only parity may move; this also
  // shows that writes to other addresses are dropped
  a_held_when_idle: assert property (i_ce && !sw_write && !i_alu.arith_en && !i_alu.bit_en
                                     |=> $stable(o_status[PSF_BIT_CARRY:PSF_BIT_USER_B]))
    else $error("status moved with no write and no core update");

  // Bank base after a write follows the written bank field directly
  a_bank_base_write: assert property (i_ce && sw_write
                                      |=> o_bank_base == (5'($past(i_wdata[PSF_BIT_BANK_HI:PSF_BIT_BANK_LO]))
                                                          << PSF_BANK_SHIFT))
    else $error("bank base did not follow written bank field");

  // Low clock enable freezes every output, read data included
  a_frozen_no_ce: assert property (!i_reset && !i_ce
                                   |=> $stable(o_status) && $stable(o_rdata) && $stable(o_bank_base))
    else $error("state moved while clock enable was low");

  // Read data stands until the next enabled edge only, then falls back to the idle value
  a_read_idle_zero: assert property (i_ce && !sw_read |=> o_rdata == PSF_RDATA_UNMAPPED)
    else $error("read data outlived its cycle");

  // Reset must land whatever the clock enable does, so this one is never disabled
  a_reset_values: assert property (disable iff (1'b0)
                                   i_reset |=> o_status == PSF_STATUS_RESET
                                            && o_rdata == PSF_RDATA_UNMAPPED
                                            && o_bank_base == BANK_BASE_RESET)
    else $error("outputs not at reset values after reset");

endmodule

// ---- tb/psf_alu_model.sv ----
`timescale 1ns/1ps
// ****
// Core ALU stand-in: 8-bit add or Boolean op
// ****
module psf_alu_model
  import psf_pkg::*;
(
  // Operation and operands
  input  wire logic [1:0] i_op,
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  // Flag results
  output psf_alu_t        o_alu
);
  logic [8:0] sum;
  logic [7:0] lo7;
  logic [4:0] nib;
  // Carries come from real sums, so flags stay consistent with each other
  always_comb begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    lo7 = {1'b0, i_a[6:0]} + {1'b0, i_b[6:0]};
    nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    // Op 3 raises both enables so the precedence of an add shows
    o_alu.arith_en = i_op[0];
    o_alu.carry_out = sum[8];
    o_alu.carry_bit6 = lo7[7];
    o_alu.nibble_carry = nib[4];
    o_alu.bit_en = i_op[1];
    o_alu.bit_val = i_a[0] ^ i_b[0];
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
// ****
// Status word bench
// ****
module tb import psf_pkg::*;;
  logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rst_req = 1'b1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_acc = 8'h00, op_a = 8'h00, op_b = 8'h00;
  logic [7:0] o_rdata, o_status, ex_st = 8'h00, ex_rd = 8'h00;
  logic [1:0] op = 2'h0;
  logic [4:0] o_bank_base;
  logic       o_carry;
  psf_alu_t   i_alu;
  int bad_count = 0;
  int samples_checked = 0;
  // 40 MHz core clock
  always #12.5 i_clk = ~i_clk;
  psf_alu_model u_psf_alu_model (.i_op(op), .i_a(op_a), .i_b(op_b), .o_alu(i_alu));
  psf_top u_psf_top (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_alu(i_alu),
    .i_acc(i_acc), .o_status(o_status), .o_carry(o_carry), .o_bank_base(o_bank_base));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Core results win over a software write of the same bit
  function automatic logic [7:0] nxt(input logic [7:0] s);
    logic [7:0] n;
    n = (i_wr && i_addr == PSF_ADDR_STATUS_WORD) ? i_wdata : s;
    if (i_alu.arith_en)
      n = {i_alu.carry_out, i_alu.nibble_carry, n[5:3], i_alu.carry_bit6 ^ i_alu.carry_out, n[1:0]};
    else if (i_alu.bit_en)
      n[7] = i_alu.bit_val;
    n[0] = ^i_acc;
    return n;
  endfunction
  // Account for the edge just taken, drive the next cycle, check mid-cycle
  task automatic step(input logic [1:0] m, o, input logic [7:0] ad, wd, a, b, ac, input logic ce);
    @(posedge i_clk);
    if (i_reset) begin
      ex_st = PSF_STATUS_RESET;
      ex_rd = PSF_RDATA_UNMAPPED;
    end else if (i_ce) begin
      ex_rd = (i_rd && i_addr == PSF_ADDR_STATUS_WORD) ? ex_st : PSF_RDATA_UNMAPPED;
      ex_st = nxt(ex_st);
    end
    i_wr <= (m == 2'h1);
    i_rd <= (m == 2'h2);
    op <= o;
    i_addr <= ad;
    i_wdata <= wd;
    op_a <= a;
    op_b <= b;
    i_acc <= ac;
    i_ce <= ce;
    i_reset <= rst_req;
    @(negedge i_clk);
    chk(o_status, ex_st);
    chk(o_rdata, ex_rd);
    chk({3'h0, o_bank_base}, {3'h0, ex_st[4:3], 3'h0});
    chk({7'h0, o_carry}, {7'h0, ex_st[7]});
  endtask
  initial begin
    void'($urandom(32'h82EB90B1));
    // Reset is seen at five edges; the step after them releases it
    repeat (4) step(2'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    rst_req = 1'b0;
    // Write clashing with an add, back-to-back read, Boolean op, bank sweep
    step(2'h1, 2'h1, PSF_ADDR_STATUS_WORD, 8'hFF, 8'h80, 8'h80, 8'h01, 1'b1);
    step(2'h2, 2'h2, PSF_ADDR_STATUS_WORD, 8'h00, 8'h01, 8'h00, 8'h03, 1'b1);
    for (int v = 0; v < 4; v++) begin
      step(2'h1, 2'h0, PSF_ADDR_STATUS_WORD, 8'(v << 3), 8'h00, 8'h00, 8'h7F, 1'b1);
    end
    step(2'h2, 2'h0, 8'hD1, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    // Add and Boolean op together: the carry of the add must win
    step(2'h0, 2'h3, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h00, 1'b1);
    step(2'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    $display("directed test done");
    repeat (400) step(2'($urandom % 3), 2'($urandom % 4), ($urandom % 4) ? PSF_ADDR_STATUS_WORD : 8'($urandom),
      8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 1'(($urandom % 5) != 0));
    $display("random test done");
    // Reset in mid-run: a write beside the first reset edge must be dropped
    rst_req = 1'b1;
    step(2'h1, 2'h0, PSF_ADDR_STATUS_WORD, 8'hFF, 8'h00, 8'h00, 8'h00, 1'b1);
    step(2'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    rst_req = 1'b0;
    step(2'h2, 2'h0, PSF_ADDR_STATUS_WORD, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    step(2'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    $display("reset test done");
    final_report;
  end
  // Hang guard, well past the 420 or so cycles the tests need
  initial begin
    #60000;
    bad_count++;
    final_report;
  end
endmodule
